// File: rtl/latch_select_substatus_report.sv
// latch source decode, latch capture and substatus / extension status report
// assumes commands, inputs and flags are synchronous to clock
`include "latch_select_consts.svh"

module latch_select_substatus_report (
	input  wire logic                      clock,               // 250 MHz clock
	input  wire logic                      rst,                 // sync reset, high
	input  wire logic                      cmdValid,            // command strobe, one cycle
	input  wire latch_select_pkg::command_t cmdCode,            // command or subcommand code
	input  wire logic [7:0]                latchSourceSelect,   // latch source select byte
	input  wire logic [7:0]                captureModeParam,    // continuous capture mode param
	input  wire logic [3:0]                seqLength,           // steps per continuous sequence
	input  wire logic                      subcmdAlarmIn,       // subcommand alarm condition
	input  wire logic                      subcmdWarnIn,        // subcommand warning condition
	input  wire logic                      subcmdBusyIn,        // subcommand processing busy
	input  wire logic                      originPulse,         // encoder origin pulse
	input  wire logic                      externalTriggerOne,  // external latch input one
	input  wire logic                      externalTriggerTwo,  // external latch input two
	input  wire logic                      externalTriggerThree,// external latch input three
	input  wire logic [31:0]               feedbackPos,         // feedback position
	output logic [31:0]                    latchPos,            // captured position
	output logic                           latchDone,           // capture pulse, one cycle
	output logic [7:0]                     substatusByte,       // frame byte 18
	output logic [15:0]                    extStatusWord,       // frame bytes 28..29
	output logic [15:0]                    ioMonitorWord        // input monitor word
);
	latch_select_pkg::core_t cur_r, cur_nxt;

	logic [3:0] trigNow;
	logic [3:0] rise;
	logic       srcUsed;
	logic       selHit;
	logic       stepWrap;

	// true for the commands that read the select byte
	function automatic logic usesSelect(input latch_select_pkg::command_t c,
	                                    input logic [7:0] mode);
		usesSelect = (c == latch_select_pkg::CMD_LATCH) ||
		             (c == latch_select_pkg::CMD_EXPOS) ||
		             (c == latch_select_pkg::CMD_HOMING) ||
		             (c == latch_select_pkg::CMD_SERVO) ||
		             ((c == latch_select_pkg::CMD_CSTART) && (mode == `CAP_MODE_ZERO));
	endfunction : usesSelect

	// next state; edges are taken against last cycle's raw inputs
	always_comb begin
		cur_nxt   = cur_r;
		trigNow   = {externalTriggerThree, externalTriggerTwo, externalTriggerOne, originPulse};
		rise      = trigNow & ~cur_r.trigPrev;
		srcUsed   = cmdValid && usesSelect(cmdCode, captureModeParam);
		selHit    = rise[cur_r.srcSel] && (cur_r.state != latch_select_pkg::ST_IDLE);
		stepWrap  = (cur_r.stepNum + 4'h1) >= seqLength;
		cur_nxt.trigPrev  = trigNow;
		cur_nxt.latchDone = 1'b0;
		if (srcUsed) begin
			cur_nxt.srcSel = latchSourceSelect[1:0];
		end
		// capture only from the selected source
		if (selHit) begin
			cur_nxt.latchPos  = feedbackPos;
			cur_nxt.latchDone = 1'b1;
		end
		unique case (cur_r.state)
			latch_select_pkg::ST_IDLE: begin
			end
			latch_select_pkg::ST_SINGLE: begin
				cur_nxt.cmpCount = 8'h00;
				cur_nxt.stepNum  = 4'h0;
				if (selHit) begin
					cur_nxt.state = latch_select_pkg::ST_IDLE;
				end
			end
			latch_select_pkg::ST_CONT: begin
				// each capture is one step; a full pass bumps the count
				if (selHit) begin
					if (stepWrap) begin
						cur_nxt.stepNum  = 4'h0;
						cur_nxt.cmpCount = cur_r.cmpCount + 8'h01;
					end else begin
						cur_nxt.stepNum = cur_r.stepNum + 4'h1;
					end
				end
			end
		endcase
		if (cmdValid) begin
			if (cmdCode == latch_select_pkg::CMD_LATCH || cmdCode == latch_select_pkg::CMD_EXPOS ||
			    cmdCode == latch_select_pkg::CMD_HOMING ||
			    cmdCode == latch_select_pkg::CMD_SERVO) begin
				cur_nxt.state    = latch_select_pkg::ST_SINGLE;
				cur_nxt.cmpCount = 8'h00;
				cur_nxt.stepNum  = 4'h0;
			end
			if (cmdCode == latch_select_pkg::CMD_CSTART) begin
				cur_nxt.state    = latch_select_pkg::ST_CONT;
				cur_nxt.cmpCount = 8'h00;
				cur_nxt.stepNum  = 4'h0;
			end
			if (cmdCode == latch_select_pkg::CMD_CSTOP) begin
				cur_nxt.state = latch_select_pkg::ST_IDLE;
			end
			// monitoring switched on by these three subcommands
			if (cmdCode == latch_select_pkg::CMD_MON || cmdCode == latch_select_pkg::CMD_CSTART ||
			    cmdCode == latch_select_pkg::CMD_CSTOP) begin
				cur_nxt.extEnable = 1'b1;
			end
		end
		// reserved bits stay zero
		cur_nxt.substatus = 8'h00;
		cur_nxt.substatus[`SUB_ALARM_BIT] = subcmdAlarmIn;
		cur_nxt.substatus[`SUB_WARN_BIT]  = subcmdWarnIn;
		cur_nxt.substatus[`SUB_READY_BIT] = ~subcmdBusyIn;
		cur_nxt.extStatus = 16'h0000;
		if (cur_r.extEnable) begin
			cur_nxt.extStatus = {4'h0, cur_r.stepNum, cur_r.cmpCount};
		end
		cur_nxt.ioMonitor = 16'h0000;
		cur_nxt.ioMonitor[`MON_ORIGIN_BIT] = originPulse;
		cur_nxt.ioMonitor[`MON_TRIG_ONE_BIT]   = externalTriggerOne;
		cur_nxt.ioMonitor[`MON_TRIG_TWO_BIT]   = externalTriggerTwo;
		cur_nxt.ioMonitor[`MON_TRIG_THREE_BIT] = externalTriggerThree;
	end

	// whole state in one register; reset values are constants
	always_ff @(posedge clock) begin
		if (rst) begin
			cur_r       <= '0;
			cur_r.state <= latch_select_pkg::ST_IDLE;
		end else begin
			cur_r <= cur_nxt;
		end
	end

	assign latchPos      = cur_r.latchPos;
	assign latchDone     = cur_r.latchDone;
	assign substatusByte = cur_r.substatus;
	assign extStatusWord = cur_r.extStatus;
	assign ioMonitorWord = cur_r.ioMonitor;

	AST_SEL_DECODE: assert property (@(posedge clock) disable iff (rst)
		cmdValid && cmdCode == latch_select_pkg::CMD_LATCH
		|=> cur_r.srcSel == $past(latchSourceSelect[1:0]))
		else $error("select bits not taken");
	AST_SEL_IGNORED: assert property (@(posedge clock) disable iff (rst)
		cmdValid && cmdCode == latch_select_pkg::CMD_CSTART && captureModeParam != `CAP_MODE_ZERO
		|=> $stable(cur_r.srcSel))
		else $error("select taken in nonzero mode");
	AST_ALARM: assert property (@(posedge clock) disable iff (rst)
		##1 substatusByte[`SUB_ALARM_BIT] == $past(subcmdAlarmIn) && substatusByte[7:3] == 5'h00)
		else $error("alarm bit wrong");
	AST_READY: assert property (@(posedge clock) disable iff (rst)
		subcmdBusyIn |=> !substatusByte[`SUB_READY_BIT])
		else $error("ready while busy");
	AST_EXT_EN: assert property (@(posedge clock) disable iff (rst)
		cmdValid && cmdCode == latch_select_pkg::CMD_MON |=> cur_r.extEnable)
		else $error("monitor not enabled");
	AST_COUNT: assert property (@(posedge clock) disable iff (rst)
		cur_r.state == latch_select_pkg::ST_CONT && selHit && stepWrap && !cmdValid
		|=> cur_r.cmpCount == $past(cur_r.cmpCount) + 8'h01)
		else $error("count not advanced");
	AST_STEP: assert property (@(posedge clock) disable iff (rst)
		cur_r.extEnable |=> extStatusWord[11:8] == $past(cur_r.stepNum))
		else $error("step number not shown");
	AST_SINGLE_ZERO: assert property (@(posedge clock) disable iff (rst)
		cur_r.state == latch_select_pkg::ST_SINGLE
		|=> cur_r.cmpCount == 8'h00 && cur_r.stepNum == 4'h0)
		else $error("counts nonzero in single latch");
	AST_IOMON: assert property (@(posedge clock) disable iff (rst)
		##1 ioMonitorWord[`MON_TRIG_THREE_BIT] == $past(externalTriggerThree))
		else $error("input three monitor wrong");
	AST_ORIGIN: assert property (@(posedge clock) disable iff (rst)
		##1 ioMonitorWord[`MON_ORIGIN_BIT] == $past(originPulse))
		else $error("origin monitor wrong");
	AST_CAPTURE: assert property (@(posedge clock) disable iff (rst)
		latchDone |-> latchPos == $past(feedbackPos) && $past(rise[cur_r.srcSel]))
		else $error("capture from wrong source");

	// status words carry last cycle's inputs and nothing else
	AST_WARN: assert property (@(posedge clock) disable iff (rst)
		##1 substatusByte[`SUB_WARN_BIT] == $past(subcmdWarnIn))
		else $error("warning bit wrong");
	AST_IOMON_ONE: assert property (@(posedge clock) disable iff (rst)
		##1 ioMonitorWord[`MON_TRIG_ONE_BIT] == $past(externalTriggerOne))
		else $error("input one monitor wrong");
	AST_IOMON_TWO: assert property (@(posedge clock) disable iff (rst)
		##1 ioMonitorWord[`MON_TRIG_TWO_BIT] == $past(externalTriggerTwo))
		else $error("input two monitor wrong");

	// the select byte must survive commands that do not own it
	AST_SRC_KEEP: assert property (@(posedge clock) disable iff (rst)
		cmdValid && (cmdCode == latch_select_pkg::CMD_MON ||
		cmdCode == latch_select_pkg::CMD_CSTOP || cmdCode == latch_select_pkg::CMD_NONE)
		|=> $stable(cur_r.srcSel))
		else $error("select taken by a foreign command");

	// monitoring, once on, stays on; while off the word reads zero
	AST_EXT_CONT: assert property (@(posedge clock) disable iff (rst)
		cmdValid && (cmdCode == latch_select_pkg::CMD_CSTART ||
		cmdCode == latch_select_pkg::CMD_CSTOP) |=> cur_r.extEnable)
		else $error("capture subcommand did not enable monitoring");
	AST_EXT_OFF: assert property (@(posedge clock) disable iff (rst)
		!cur_r.extEnable |=> extStatusWord == 16'h0000)
		else $error("extension status shown while disabled");

	// counters advance only on a selected capture in continuous mode
	AST_COUNT_SHOWN: assert property (@(posedge clock) disable iff (rst)
		cur_r.extEnable |=> extStatusWord[7:0] == $past(cur_r.cmpCount))
		else $error("count not shown");
	AST_CONT_HOLD: assert property (@(posedge clock) disable iff (rst)
		cur_r.state == latch_select_pkg::ST_CONT && !selHit && !cmdValid
		|=> $stable(cur_r.cmpCount) && $stable(cur_r.stepNum))
		else $error("counters moved without a capture");
	AST_STEP_ADV: assert property (@(posedge clock) disable iff (rst)
		cur_r.state == latch_select_pkg::ST_CONT && selHit && !stepWrap && !cmdValid
		|=> cur_r.stepNum == $past(cur_r.stepNum) + 4'h1)
		else $error("step number not advanced");
	AST_SINGLE_EXT: assert property (@(posedge clock) disable iff (rst)
		cur_r.state == latch_select_pkg::ST_SINGLE |=> extStatusWord == 16'h0000)
		else $error("extension status nonzero in single latch");

	// a capture needs a rising edge on the selected source outside idle
	AST_SEL_HIT: assert property (@(posedge clock) disable iff (rst)
		rise[cur_r.srcSel] && cur_r.state != latch_select_pkg::ST_IDLE
		|=> latchDone && latchPos == $past(feedbackPos))
		else $error("selected edge not captured");
	AST_UNSEL: assert property (@(posedge clock) disable iff (rst)
		!rise[cur_r.srcSel] |=> !latchDone)
		else $error("capture without a selected edge");
	AST_IDLE_NO_CAP: assert property (@(posedge clock) disable iff (rst)
		cur_r.state == latch_select_pkg::ST_IDLE |=> !latchDone)
		else $error("capture while idle");
endmodule : latch_select_substatus_report

// File: rtl/latch_select_consts.svh
// constants for the latch source select and substatus report block
// assumes one 250 MHz clock and a synchronous active-high reset
`ifndef LATCH_SELECT_CONSTS_SVH
`define LATCH_SELECT_CONSTS_SVH
`define SEL_ORIGIN      2'h0
`define SEL_EXT_ONE     2'h1
`define SEL_EXT_TWO     2'h2
`define SEL_EXT_THREE   2'h3
`define SUB_ALARM_BIT   0
`define SUB_WARN_BIT    1
`define SUB_READY_BIT   2
`define MON_ORIGIN_BIT  5
`define MON_TRIG_ONE_BIT    6
`define MON_TRIG_TWO_BIT    7
`define MON_TRIG_THREE_BIT  8
`define CAP_MODE_ZERO   8'h00
`endif

// File: rtl/latch_select_pkg.sv
// types for the latch source select and substatus report block
// assumes the constants header is included by the design file
package latch_select_pkg;
	// command codes presented on the command port
	typedef enum logic [2:0] {
		CMD_NONE   = 3'h0,
		CMD_LATCH  = 3'h1,
		CMD_EXPOS  = 3'h2,
		CMD_HOMING = 3'h3,
		CMD_CSTART = 3'h4,
		CMD_CSTOP  = 3'h5,
		CMD_SERVO  = 3'h6,
		CMD_MON    = 3'h7
	} command_t;

	// latch activity state, one-hot
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_SINGLE = 3'b010,
		ST_CONT   = 3'b100
	} latch_state_t;

	typedef struct packed {
		latch_state_t state;
		logic [1:0]   srcSel;
		logic [3:0]   trigPrev;
		logic [31:0]  latchPos;
		logic         latchDone;
		logic [7:0]   cmpCount;
		logic [3:0]   stepNum;
		logic         extEnable;
		logic [7:0]   substatus;
		logic [15:0]  extStatus;
		logic [15:0]  ioMonitor;
	} core_t;
endpackage : latch_select_pkg

// File: verif/motion_master_model.sv
// motion controller model: sends commands and subcommands into the block
// assumes the bench calls send just after a rising clock edge
module motion_master_model (
	input  wire logic                  clock,     // block clock
	input  wire logic [7:0]            substatus, // substatus byte from the block
	output latch_select_pkg::command_t cmdCode,   // command code
	output logic                       cmdValid,  // one-cycle strobe
	output logic [7:0]                 selByte,   // latch source select byte
	output logic [7:0]                 modeParam  // capture mode param
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		cmdValid = 1'b0;
		cmdCode = latch_select_pkg::CMD_NONE;
		selByte = 8'hFF;
		modeParam = 8'h00;
	end

	// a gap edge first, so the strobe is never lowered and raised in one step
	task automatic send(input latch_select_pkg::command_t code, input logic [1:0] src,
		input logic [7:0] mode);
		int n;
		n = 0;
		@(posedge clock);
		while (substatus[2] !== 1'b1 && n < 50) begin
			@(posedge clock);
			n++;
		end
		cmdValid <= 1'b1;
		cmdCode <= code;
		selByte <= {6'h00, src};
		modeParam <= mode;
		@(posedge clock);
		cmdValid <= 1'b0;
		cmdCode <= latch_select_pkg::CMD_NONE;
		selByte <= {6'h3F, ~src}; // released byte never repeats the last value
	endtask : send
endmodule : motion_master_model

// File: verif/latch_select_substatus_report_bench.sv
// self-checking bench: controller model, trigger pulses, capture queue
// assumes the design and package are compiled first
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module latch_select_substatus_report_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0, rst = 1'b1, alarm = 1'b0, warn = 1'b0, busy = 1'b0, cmdValid, latchDone;
	logic [3:0] trig = 4'h0, seqLength = 4'h2;
	logic [7:0] sel, mode, substatusByte;
	logic [15:0] extStatusWord, ioMonitorWord;
	logic [31:0] feedbackPos = 32'h0, latchPos, expPos, r;
	logic [1:0] cur;
	latch_select_pkg::command_t cmdCode;
	logic [31:0] expQ [$];
	int errors = 0, check_count = 0, seed = 19;
	latch_select_pkg::command_t codes [5] = '{latch_select_pkg::CMD_EXPOS,
		latch_select_pkg::CMD_HOMING, latch_select_pkg::CMD_SERVO,
		latch_select_pkg::CMD_MON, latch_select_pkg::CMD_CSTOP};

	always #2 clock = ~clock;

	motion_master_model u_ctl (.clock(clock), .substatus(substatusByte), .cmdCode(cmdCode),
		.cmdValid(cmdValid), .selByte(sel), .modeParam(mode));
	latch_select_substatus_report u_dut (.clock(clock), .rst(rst), .cmdValid(cmdValid),
		.cmdCode(cmdCode), .latchSourceSelect(sel), .captureModeParam(mode),
		.seqLength(seqLength), .subcmdAlarmIn(alarm), .subcmdWarnIn(warn),
		.subcmdBusyIn(busy), .originPulse(trig[0]), .externalTriggerOne(trig[1]),
		.externalTriggerTwo(trig[2]), .externalTriggerThree(trig[3]),
		.feedbackPos(feedbackPos), .latchPos(latchPos), .latchDone(latchDone),
		.substatusByte(substatusByte), .extStatusWord(extStatusWord),
		.ioMonitorWord(ioMonitorWord));

	// capture watcher: any pulse without a queued note is a stray capture
	always @(negedge clock) if (latchDone === 1'b1) begin
		expPos = (expQ.size() > 0) ? expQ.pop_front() : ~latchPos;
		`CHK(latchPos, expPos)
	end

	// one trigger pulse; position held while the edge is seen
	task automatic pulse(input logic [1:0] src, input logic hit);
		r = $random(seed);
		@(posedge clock);
		trig[src] <= 1'b1;
		feedbackPos <= r;
		if (hit) expQ.push_back(r);
		repeat (3) @(posedge clock);
		trig[src] <= 1'b0;
		feedbackPos <= ~r;
		repeat (3) @(posedge clock);
		#1;
	endtask : pulse

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : wrap_up

	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#40000;
		errors++;
		wrap_up();
	end

	initial begin
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		// idle: status mirrors inputs, triggers start nothing
		for (int i = 0; i < 8; i++) begin
			@(posedge clock);
			r = $random(seed);
			{alarm, warn, busy} <= r[2:0];
			trig <= r[6:3];
			repeat (3) @(posedge clock);
			#1;
			`CHK(substatusByte, {5'h00, ~r[0], r[1], r[2]})
			`CHK(ioMonitorWord, {7'h00, r[6:3], 5'h00})
			`CHK(extStatusWord, 16'h0000)
		end
		@(posedge clock);
		{alarm, warn, busy, trig} <= 7'h00;
		$display("status mirror test done");
		// each source; single latch ends after one capture
		for (int s = 0; s < 4; s++) begin
			u_ctl.send(latch_select_pkg::CMD_LATCH, 2'(s), 8'h00);
			pulse(2'(s + 1), 1'b0);
			pulse(2'(s), 1'b1);
			pulse(2'(s), 1'b0);
		end
		$display("source select test done");
		// select taken by some commands only; capture start with mode 5 keeps it
		cur = 2'h3;
		for (int i = 0; i < 5; i++) begin
			u_ctl.send(codes[i], 2'(i), 8'h00);
			if (codes[i] inside {latch_select_pkg::CMD_EXPOS, latch_select_pkg::CMD_HOMING,
				latch_select_pkg::CMD_SERVO}) cur = 2'(i);
			u_ctl.send(latch_select_pkg::CMD_CSTART, cur + 2'h1, 8'h05);
			pulse(cur + 2'h1, 1'b0);
			pulse(cur, 1'b1);
			u_ctl.send(latch_select_pkg::CMD_CSTOP, cur, 8'h00);
		end
		$display("command select test done");
		// ordinary latch zeroes count and step; continuous counts with length 2
		u_ctl.send(latch_select_pkg::CMD_LATCH, 2'h1, 8'h00);
		repeat (3) @(posedge clock);
		#1;
		`CHK(extStatusWord, 16'h0000)
		pulse(2'h1, 1'b1);
		u_ctl.send(latch_select_pkg::CMD_CSTART, 2'h0, 8'h00);
		pulse(2'h0, 1'b1);
		`CHK(extStatusWord, 16'h0100)
		pulse(2'h0, 1'b1);
		`CHK(extStatusWord, 16'h0001)
		pulse(2'h0, 1'b1);
		`CHK(extStatusWord, 16'h0101)
		u_ctl.send(latch_select_pkg::CMD_CSTOP, 2'h0, 8'h00);
		pulse(2'h0, 1'b0);
		`CHK(expQ.size(), 0)
		$display("continuous count test done");
		wrap_up();
	end
endmodule : latch_select_substatus_report_bench
